// ### core/adc_interface_control_regs.sv
// control registers of the adc receive interface with its sample path and converter controls
//
// Added by the designer: the Avalon-MM slave port.
`include "adc_ctrl_params.svh"

// What this block does
// - writing the load bit high then low loads the tap field into the delay line
// - bits 8:0 of the first register give the tap count of a 512-tap line
// - the tap field resets to a build-time parameter value
// - bits 31:16 of the second register give the overload threshold
// - bits 6:5 pick the overload source: adc, trim, external or disabled
// - bit 4 drives the sleep output: 0 deep sleep, 1 light sleep
// - bit 3 drives the dither output: 0 off, 1 on
// - bit 2 set converts samples to two's complement, clear passes them unchanged
// - bits 1:0 add a whole-sample delay to the data, reset to zero
// - threshold and bits 6:2 reset to build-time parameter values
// - the overload indicator output is active low
// - sleep and dither outputs are active high
module adc_interface_control_regs
#(
   parameter int                    SAMPLE_W        = 16,
   parameter logic [8:0]            INIT_TAP_DELAY  = 9'h000,
   parameter logic [15:0]           INIT_THRESH     = 16'h0000,
   parameter adc_ctrl_pkg::led_src_t INIT_LED_SEL   = adc_ctrl_pkg::LED_SRC_ADC,
   parameter logic                  INIT_SLEEP      = 1'h0,
   parameter logic                  INIT_DITHER     = 1'h0,
   parameter logic                  INIT_TWOS       = 1'h0
)
(
   // clock and reset
   input  wire logic                        sys_clk_i,
   input  wire logic                        nrst_i,
   // avalon-mm slave
   input  wire logic [`ADC_ADDR_W-1:0]      avs_address_i,
   input  wire logic                        avs_read_i,
   input  wire logic                        avs_write_i,
   input  wire logic [31:0]                 avs_writedata_i,
   input  wire logic [3:0]                  avs_byteenable_i,
   output logic      [31:0]                 avs_readdata_o,
   output logic                             avs_waitrequest_o,
   // sample path
   input  wire logic [SAMPLE_W-1:0]         sample_i,
   input  wire logic                        sample_valid_i,
   output logic      [SAMPLE_W-1:0]         sample_o,
   output logic                             sample_valid_o,
   // input delay line
   output adc_ctrl_pkg::delay_cmd_t         input_delay_line_o,
   // overload detection
   input  wire logic                        adc_ovld_i,
   input  wire logic                        trim_ovld_i,
   input  wire logic                        ext_ovld_i,
   output logic      [`ADC_THRESH_W-1:0]    ovld_thresh_o,
   output logic                             ovld_ind_n_o,
   // converter controls
   output logic                             adc_sleep_light_o,
   output logic                             adc_dither_o
);

   localparam int TAPS = `ADC_IDLY_STAGES + 1;

   adc_ctrl_pkg::delay_ctrl_t dly_q;
   adc_ctrl_pkg::path_ctrl_t  path_q;

   logic                          wait_q;
   logic [31:0]                   rdata_q;
   logic                          req;
   logic                          wr_en;
   logic [31:0]                   wmask;
   logic                          strobe_prev_q;
   logic                          load_q;
   logic [`ADC_TAP_W-1:0]         tap_out_q;
   logic [`ADC_STAT_CNT_W-1:0]    load_cnt_q;
   logic                          ovld_sel;
   logic                          ovld_n_q;
   logic                          sleep_q;
   logic                          dither_q;
   logic [`ADC_THRESH_W-1:0]      thresh_q;
   logic [SAMPLE_W-1:0]           conv;
   logic [SAMPLE_W-1:0]           tap_data [TAPS];
   logic [SAMPLE_W-1:0]           sample_q;
   logic                          valid_q;

   // bus handshake
   // one wait state lets the read data come from a flop; writes land on the
   // edge where waitrequest is seen low, as the master expects
   assign req = avs_read_i | avs_write_i;
   assign wr_en = avs_write_i & ~wait_q;

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         wait_q <= 1'h1;
      else if (req && wait_q)
         wait_q <= 1'h0;
      else
         wait_q <= 1'h1;
   end

   always_comb
   begin
      wmask = '0;
      for (int b = 0; b < 4; b++)
      begin
         if (avs_byteenable_i[b])
            wmask[b*8 +: 8] = 8'hFF;
      end
   end

   // read data are captured during the wait state and stand at the ack edge
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rdata_q <= 32'h0;
      else if (avs_read_i && wait_q)
      begin
         case (avs_address_i)
            `ADC_OFS_DELAY_CTRL: rdata_q <= dly_q;
            `ADC_OFS_PATH_CTRL:  rdata_q <= path_q;
            `ADC_OFS_STATUS:
            begin
               rdata_q <= 32'h0;
               rdata_q[`ADC_STAT_LED_BIT] <= ovld_sel;
               rdata_q[`ADC_STAT_CNT_LSB +: `ADC_STAT_CNT_W] <= load_cnt_q;
            end
            default:             rdata_q <= 32'h0;
         endcase
      end
   end

   // first control register
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dly_q      <= '0;
         dly_q.tap  <= INIT_TAP_DELAY;
         dly_q.load <= `ADC_LOAD_RST;
      end
      else if (wr_en && avs_address_i == `ADC_OFS_DELAY_CTRL)
      begin
         dly_q.tap  <= (avs_writedata_i[8:0] & wmask[8:0]) | (dly_q.tap & ~wmask[8:0]);
         if (wmask[`ADC_LOAD_BIT])
            dly_q.load <= avs_writedata_i[`ADC_LOAD_BIT];
      end
   end

   // second control register; reserved bits stay zero
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         path_q             <= '0;
         path_q.thresh      <= INIT_THRESH;
         path_q.led_sel     <= INIT_LED_SEL;
         path_q.sleep_light <= INIT_SLEEP;
         path_q.dither      <= INIT_DITHER;
         path_q.twos        <= INIT_TWOS;
         path_q.int_delay   <= `ADC_IDLY_RST;
      end
      else if (wr_en && avs_address_i == `ADC_OFS_PATH_CTRL)
      begin
         if (wmask[`ADC_THRESH_LSB])
            path_q.thresh[7:0] <= avs_writedata_i[23:16];
         if (wmask[`ADC_THRESH_LSB + 8])
            path_q.thresh[15:8] <= avs_writedata_i[31:24];
         if (wmask[0])
         begin
            path_q.led_sel     <= adc_ctrl_pkg::led_src_t'(avs_writedata_i[`ADC_LED_LSB +: 2]);
            path_q.sleep_light <= avs_writedata_i[`ADC_SLEEP_BIT];
            path_q.dither      <= avs_writedata_i[`ADC_DITHER_BIT];
            path_q.twos        <= avs_writedata_i[`ADC_TWOS_BIT];
            path_q.int_delay   <= avs_writedata_i[`ADC_IDLY_LSB +: `ADC_IDLY_W];
         end
      end
   end

   // delay-line load: fires on the falling edge of the strobe bit, so a
   // single write of 1 alone never disturbs the line
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         strobe_prev_q <= 1'h0;
      else
         strobe_prev_q <= dly_q.load;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         load_q    <= 1'h0;
         tap_out_q <= INIT_TAP_DELAY;
      end
      else
      begin
         load_q <= strobe_prev_q & ~dly_q.load;
         if (strobe_prev_q && !dly_q.load)
            tap_out_q <= dly_q.tap;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         load_cnt_q <= '0;
      else if (load_q)
         load_cnt_q <= load_cnt_q + 8'h01;
   end

   assign input_delay_line_o.load = load_q;
   assign input_delay_line_o.tap  = tap_out_q;

   // overload indicator and converter controls
   always_comb
   begin
      case (path_q.led_sel)
         adc_ctrl_pkg::LED_SRC_ADC:  ovld_sel = adc_ovld_i;
         adc_ctrl_pkg::LED_SRC_TRIM: ovld_sel = trim_ovld_i;
         adc_ctrl_pkg::LED_SRC_EXT:  ovld_sel = ext_ovld_i;
         default:                    ovld_sel = 1'h0;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ovld_n_q <= 1'h1;
      else
         ovld_n_q <= ~ovld_sel;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sleep_q  <= INIT_SLEEP;
         dither_q <= INIT_DITHER;
         thresh_q <= INIT_THRESH;
      end
      else
      begin
         sleep_q  <= path_q.sleep_light;
         dither_q <= path_q.dither;
         thresh_q <= path_q.thresh;
      end
   end

   // sample path: offset binary to two's complement is an msb flip
   always_comb
   begin
      conv = sample_i;
      if (path_q.twos)
         conv[SAMPLE_W-1] = ~sample_i[SAMPLE_W-1];
   end

   // stage 0 is the converted sample, stages 1..3 the extra delay;
   // stages advance per valid sample so the delay counts samples, not sys clocks
   assign tap_data[0] = conv;

   genvar s;
   generate
      for (s = 1; s < TAPS; s++)
      begin : g_stage
         sample_delay_stage
         #(
            .W (SAMPLE_W)
         )
         u_stage
         (
            .sys_clk_i (sys_clk_i),
            .nrst_i    (nrst_i),
            .adv_i     (sample_valid_i),
            .data_i    (tap_data[s-1]),
            .data_o    (tap_data[s])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sample_q <= '0;
         valid_q  <= 1'h0;
      end
      else
      begin
         valid_q <= sample_valid_i;
         if (sample_valid_i)
            sample_q <= tap_data[path_q.int_delay];
      end
   end

   assign avs_readdata_o    = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign sample_o          = sample_q;
   assign sample_valid_o    = valid_q;
   assign ovld_thresh_o     = thresh_q;
   assign ovld_ind_n_o      = ovld_n_q;
   assign adc_sleep_light_o = sleep_q;
   assign adc_dither_o      = dither_q;

endmodule

// ### core/adc_ctrl_params.svh
// offsets, field positions, reset values and timing counts of the adc control registers
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

`define ADC_ADDR_W           4
`define ADC_OFS_DELAY_CTRL   4'h0
`define ADC_OFS_PATH_CTRL    4'h4
`define ADC_OFS_STATUS       4'hC

`define ADC_TAP_LSB          0
`define ADC_TAP_W            9
`define ADC_TAP_COUNT        512
`define ADC_LOAD_BIT         9
`define ADC_LOAD_RST         1'h0

`define ADC_THRESH_LSB       16
`define ADC_THRESH_W         16
`define ADC_LED_LSB          5
`define ADC_SLEEP_BIT        4
`define ADC_DITHER_BIT       3
`define ADC_TWOS_BIT         2
`define ADC_IDLY_LSB         0
`define ADC_IDLY_W           2
`define ADC_IDLY_RST         2'h0
`define ADC_IDLY_STAGES      3

`define ADC_STAT_LED_BIT     0
`define ADC_STAT_CNT_LSB     8
`define ADC_STAT_CNT_W       8

`define ADC_ACK_CYCLES       1

`endif

// ### core/adc_ctrl_pkg.sv
// types shared by the adc control register block
package adc_ctrl_pkg;

   typedef enum logic [1:0]
   {
      LED_SRC_ADC  = 2'h0,
      LED_SRC_TRIM = 2'h1,
      LED_SRC_EXT  = 2'h2,
      LED_SRC_OFF  = 2'h3
   } led_src_t;

   typedef struct packed
   {
      logic [21:0] rsvd;
      logic        load;
      logic [8:0]  tap;
   } delay_ctrl_t;

   typedef struct packed
   {
      logic [15:0] thresh;
      logic [8:0]  rsvd;
      led_src_t    led_sel;
      logic        sleep_light;
      logic        dither;
      logic        twos;
      logic [1:0]  int_delay;
   } path_ctrl_t;

   typedef struct packed
   {
      logic        load;
      logic [8:0]  tap;
   } delay_cmd_t;

endpackage

// ### core/sample_delay_stage.sv
// one sample-wide register stage that advances on each valid sample
module sample_delay_stage
#(
   parameter int W = 16
)
(
   // clock and reset
   input  wire logic         sys_clk_i,
   input  wire logic         nrst_i,
   // sample in
   input  wire logic         adv_i,
   input  wire logic [W-1:0] data_i,
   // sample out
   output logic      [W-1:0] data_o
);

   logic [W-1:0] data_q;

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         data_q <= '0;
      else if (adv_i)
         data_q <= data_i;
   end

   assign data_o = data_q;

endmodule

// ### sim/adc_ctrl_assertions.sv
// checker of the adc control register block, bound to its ports
`include "adc_ctrl_params.svh"
module adc_ctrl_checker
#(
   parameter logic [8:0]             INIT_TAP_DELAY = 9'h000,
   parameter logic [15:0]            INIT_THRESH    = 16'h0000,
   parameter adc_ctrl_pkg::led_src_t INIT_LED_SEL   = adc_ctrl_pkg::LED_SRC_ADC,
   parameter logic                   INIT_SLEEP     = 1'h0,
   parameter logic                   INIT_DITHER    = 1'h0,
   parameter logic                   INIT_TWOS      = 1'h0
)
(
   // clock and reset
   input wire logic                     sys_clk_i,
   input wire logic                     nrst_i,
   // register bus
   input wire logic [`ADC_ADDR_W-1:0]   avs_address_i,
   input wire logic                     avs_write_i,
   input wire logic [31:0]              avs_writedata_i,
   input wire logic [3:0]               avs_byteenable_i,
   input wire logic                     avs_waitrequest_o,
   // controls and overload
   input wire adc_ctrl_pkg::delay_cmd_t input_delay_line_o,
   input wire logic                     adc_ovld_i,
   input wire logic                     trim_ovld_i,
   input wire logic                     ext_ovld_i,
   input wire logic [`ADC_THRESH_W-1:0] ovld_thresh_o,
   input wire logic                     ovld_ind_n_o,
   input wire logic                     adc_sleep_light_o,
   input wire logic                     adc_dither_o
);
   logic [31:0]              dly_q;
   logic [31:0]              pth_q;
   logic [31:0]              bm;
   logic [1:0]               ok_q;
   logic [3:0]               src;
   logic                     acc;
   logic                     fall;
   adc_ctrl_pkg::path_ctrl_t p;

   assign p = pth_q;
   assign acc = avs_write_i && !avs_waitrequest_o;
   assign fall = acc && avs_address_i == `ADC_OFS_DELAY_CTRL && avs_byteenable_i[1] && !avs_writedata_i[9] && dly_q[9];
   assign src = {1'b0, ext_ovld_i, trim_ovld_i, adc_ovld_i};
   always_comb
   begin
      for (int i = 0; i < 4; i++)
         bm[8*i+:8] = {8{avs_byteenable_i[i]}};
   end

   // shadows of the two registers, so outputs can be tied to what software wrote
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dly_q <= {23'h000000, INIT_TAP_DELAY};
         pth_q <= {INIT_THRESH, 9'h000, INIT_LED_SEL, INIT_SLEEP, INIT_DITHER, INIT_TWOS, 2'h0};
      end
      else if (acc && avs_address_i == `ADC_OFS_DELAY_CTRL)
         dly_q <= (dly_q & ~bm) | (avs_writedata_i & bm);
      else if (acc && avs_address_i == `ADC_OFS_PATH_CTRL)
         pth_q <= (pth_q & ~bm) | (avs_writedata_i & bm);
   end

   // $past must not reach back across a reset
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ok_q <= 2'h0;
      else
         ok_q <= {ok_q[0], 1'b1};
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_load_after_fall: assert property (ok_q[1] |-> input_delay_line_o.load == $past(fall, 2))
      else $error("delay load pulse not tied to a clearing write");
   a_tap_on_load: assert property (input_delay_line_o.load |-> input_delay_line_o.tap == $past(dly_q[8:0]))
      else $error("loaded tap differs from the register field");
   a_tap_held: assert property (ok_q[0] && !input_delay_line_o.load |-> $stable(input_delay_line_o.tap))
      else $error("tap output moved without a load");
   a_reset_values: assert property ($rose(nrst_i) |-> input_delay_line_o.tap == INIT_TAP_DELAY
      && ovld_thresh_o == INIT_THRESH && adc_sleep_light_o == INIT_SLEEP && adc_dither_o == INIT_DITHER)
      else $error("outputs differ from build-time defaults after reset");
   a_thresh_follow: assert property (ok_q[0] |-> ovld_thresh_o == $past(p.thresh))
      else $error("threshold output differs from the register");
   a_led_source: assert property (ok_q[1] |-> ovld_ind_n_o == $past(!src[p.led_sel]))
      else $error("overload indicator differs from the selected source");
   a_sleep_follow: assert property (ok_q[0] |-> adc_sleep_light_o == $past(p.sleep_light))
      else $error("sleep output differs from the register");
   a_dither_follow: assert property (ok_q[0] |-> adc_dither_o == $past(p.dither))
      else $error("dither output differs from the register");
endmodule

bind adc_interface_control_regs adc_ctrl_checker #(.INIT_TAP_DELAY(INIT_TAP_DELAY), .INIT_THRESH(INIT_THRESH),
   .INIT_LED_SEL(INIT_LED_SEL), .INIT_SLEEP(INIT_SLEEP), .INIT_DITHER(INIT_DITHER), .INIT_TWOS(INIT_TWOS))
   chk (.sys_clk_i, .nrst_i, .avs_address_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
   .avs_waitrequest_o, .input_delay_line_o, .adc_ovld_i, .trim_ovld_i, .ext_ovld_i, .ovld_thresh_o,
   .ovld_ind_n_o, .adc_sleep_light_o, .adc_dither_o);

// ### sim/adc_model.sv
// behavioural converter: sample stream with gaps and an overload flag
module adc_model
(
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   // requests from the bench
   input  wire logic        run_i,
   input  wire logic        ovld_req_i,
   // converter pins
   output logic      [15:0] sample_o,
   output logic             sample_valid_o,
   output logic             ovld_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] lfsr_q;
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         lfsr_q <= 16'hACE1;
         sample_o <= 16'h0000;
         sample_valid_o <= 1'b0;
         ovld_o <= 1'b0;
      end
      else
      begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
         sample_valid_o <= run_i && lfsr_q[0];
         // data is not held between samples, so stale values cannot pass for good ones
         sample_o <= (run_i && lfsr_q[0]) ? lfsr_q : ~sample_o;
         ovld_o <= ovld_req_i;
      end
   end
endmodule

// ### sim/adc_interface_control_regs_test.sv
// self-checking bench of the adc control register block
module adc_interface_control_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [8:0]  TAP0 = 9'h0A5;
   localparam logic [15:0] THR0 = 16'h1234;
   logic                     sys_clk_i, nrst_i, rd, wr, run, oreq, trim, ext, wt, so_v, smp_v, aov, ind_n, slp, dth;
   logic [3:0]               a, be;
   logic [31:0]              wd, rdq, q, w;
   logic [15:0]              smp, so, thr, exp_q;
   logic [3:0][15:0]         hist;
   logic [8:0]               t, ltap;
   adc_ctrl_pkg::delay_cmd_t dcmd;
   int                       error_cnt, cmp_count, seed, cyc, loads, cur_d, twos, skip;
   logic                     pend_q;

   adc_interface_control_regs #(.SAMPLE_W(16), .INIT_TAP_DELAY(TAP0), .INIT_THRESH(THR0),
      .INIT_LED_SEL(adc_ctrl_pkg::LED_SRC_EXT), .INIT_SLEEP(1'h1), .INIT_DITHER(1'h0), .INIT_TWOS(1'h1)) dut
      (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(a), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdq), .avs_waitrequest_o(wt),
      .sample_i(smp), .sample_valid_i(smp_v), .sample_o(so), .sample_valid_o(so_v), .input_delay_line_o(dcmd),
      .adc_ovld_i(aov), .trim_ovld_i(trim), .ext_ovld_i(ext), .ovld_thresh_o(thr), .ovld_ind_n_o(ind_n),
      .adc_sleep_light_o(slp), .adc_dither_o(dth));
   adc_model adc (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .run_i(run), .ovld_req_i(oreq), .sample_o(smp),
      .sample_valid_o(smp_v), .ovld_o(aov));

   function logic ind_exp(input int s, input logic [2:0] p);
      return (s == 3) ? 1'b1 : !p[s];
   endfunction

   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon cycle, entered just after a rising edge
   task bus(input logic w_i, input logic [3:0] a_i, input logic [31:0] d_i, input logic [3:0] b_i);
      wr <= w_i;
      rd <= !w_i;
      a <= a_i;
      wd <= d_i;
      be <= b_i;
      do
         @(posedge sys_clk_i);
      while (wt !== 1'b0);
      q = rdq;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge sys_clk_i);
   endtask

   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end

   // load pulses and sample path; checks start only once the delay chain holds fresh samples
   always @(posedge sys_clk_i)
   begin
      if (dcmd.load === 1'b1)
      begin
         loads++;
         ltap = dcmd.tap;
      end
      if (pend_q && skip == 0)
         check({15'h0, so_v, so}, {15'h0, 1'b1, exp_q});
      pend_q = (smp_v === 1'b1);
      if (pend_q)
      begin
         hist = {hist[2:0], smp};
         exp_q = hist[cur_d] ^ (twos ? 16'h8000 : 16'h0000);
         if (skip > 0)
            skip--;
      end
   end

   initial
   begin
      {error_cnt, cmp_count, cyc, loads, cur_d, twos} = '0;
      {nrst_i, rd, wr, run, oreq, trim, ext, pend_q} = '0;
      {a, be, wd, hist} = '0;
      seed = 32'h69d9;
      skip = 4;
      repeat (4) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      @(posedge sys_clk_i);
      check({22'h0, dcmd}, {23'h0, TAP0});
      check({thr, 14'h0, slp, dth}, {THR0, 16'h0002});
      bus(1'b0, 4'h0, 32'h0, 4'h0);
      check(q, {23'h0, TAP0});
      bus(1'b1, 4'h8, 32'hFFFFFFFF, 4'hF);
      bus(1'b0, 4'h4, 32'h0, 4'h0);
      check(q, {THR0, 16'h0054});
      $display("reset values done");
      for (int i = 1; i <= 3; i++)
      begin
         t = 9'($random(seed));
         bus(1'b1, 4'h0, {23'h0, t}, 4'h3);
         repeat (3) @(posedge sys_clk_i);
         check({23'h0, dcmd.tap}, {23'h0, (i == 1) ? TAP0 : ltap});
         // tap bit 8 shares the strobe's byte lane, so both writes carry the tap again
         bus(1'b1, 4'h0, {22'h0, 1'b1, t}, 4'h3);
         bus(1'b1, 4'h0, {23'h0, t}, 4'h3);
         repeat (3) @(posedge sys_clk_i);
         check(loads, i);
         check({23'h0, ltap}, {23'h0, t});
      end
      bus(1'b0, 4'hC, 32'h0, 4'h0);
      check(q, {16'h0, 8'h03, 8'h00});
      $display("tap loading done");
      for (int i = 0; i < 6; i++)
      begin
         w = $random(seed);
         bus(1'b1, 4'h4, w, 4'hF);
         bus(1'b0, 4'h4, 32'h0, 4'h0);
         check(q, w & 32'hFFFF007F);
         check({16'h0, thr}, {16'h0, w[31:16]});
         check({30'h0, slp, dth}, {30'h0, w[4:3]});
      end
      $display("control outputs done");
      for (int s = 0; s < 4; s++)
      begin
         bus(1'b1, 4'h4, {25'h0, 2'(s), 5'h00}, 4'h1);
         for (int p = 0; p < 8; p++)
         begin
            oreq <= p[0];
            trim <= p[1];
            ext <= p[2];
            repeat (3) @(posedge sys_clk_i);
            check({31'h0, ind_n}, {31'h0, ind_exp(s, 3'(p))});
         end
      end
      $display("overload source done");
      for (int c = 0; c < 8; c++)
      begin
         bus(1'b1, 4'h4, {25'h0, 2'h3, 2'h0, 1'(c / 4), 2'(c)}, 4'h1);
         cur_d = c % 4;
         twos = c / 4;
         skip = 4;
         run <= 1'b1;
         repeat (60) @(posedge sys_clk_i);
         run <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
      end
      $display("sample path done");
      tally_and_finish();
   end
endmodule
